// >>> logic/acs_pkg.sv
// Contract
// - Acquisition starts at conversion start if no precharge, else after precharge.
// - Acquisition start releases pin override drivers and connects channel to hold capacitor.
// - With precharge on, acquisition count zero means 256 clock cycles.
// - With precharge off, acquisition count zero disables hardware acquisition timing.
// - Two guard outputs, polarity set by guard polarity and inverted precharge bits.
// - First precharge start drives both guard outputs to guard polarity.
// - Acquisition start inverts guard A, guard B holds.
// - Double sample with inverted precharge: both guards opposite polarity, then A toggles.
// - Extra capacitance connected while sampling, disconnected during conversion.
// - Mode field: 0 basic, 1 accumulate, 2 average, 3 burst, 4 lowpass.
// - Basic mode: done flag each conversion, accumulator and counter unchanged, test every sample.
// - Accumulate: add sample term, counter increments saturating at FF, test every sample.
// - Accumulate: done flag each conversion, filter output is accumulator shifted right.
// - Average: trigger after counter reached target sets counter one, accumulator to sample.
// - Average: threshold test only when counter at least repeat target.
// - Burst: clear or a go write in idle clears, retrigger keeps the sum; repeat while counter below target; test sum.
// - Lowpass: acc = S + acc - acc>>shift, counter saturates, test once target reached.
// - Sample term is latest result, or latest minus previous when double sampling.
// - Power-of-two divisions truncate toward lower value.
// - Precharge stage runs only when precharge count is nonzero.
package acs_pkg;
    localparam int ACS_RES_W = 10;
    localparam int ACS_ACC_W = 16;
    localparam logic [8:0] ACS_ACQ_MAX = 9'h100;
    localparam logic [7:0] ACS_CNT_MAX = 8'hFF;
    localparam logic [31:0] ACS_OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] ACS_OFS_TIME = 32'h0000_0004;
    localparam logic [31:0] ACS_OFS_COMP = 32'h0000_0008;
    localparam logic [31:0] ACS_OFS_STAT = 32'h0000_000C;
    localparam logic [31:0] ACS_OFS_ACC = 32'h0000_0010;
    localparam logic [31:0] ACS_OFS_RES = 32'h0000_0014;
    localparam logic [31:0] ACS_ADDR_MASK = 32'h0000_00FC;
    localparam int ACS_CTRL_GO = 0;
    localparam int ACS_CTRL_DSEN = 1;
    localparam int ACS_CTRL_GPOL = 2;
    localparam int ACS_CTRL_IPEN = 3;
    localparam int ACS_CTRL_ACLR = 4;
    localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACS_RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        ACS_MD_BASIC = 3'h0,
        ACS_MD_ACCUM = 3'h1,
        ACS_MD_AVG = 3'h2,
        ACS_MD_BURST = 3'h3,
        ACS_MD_LPF = 3'h4
    } acs_mode_e;

    typedef enum logic [1:0] {
        ACS_ST_IDLE = 2'h0,
        ACS_ST_PRE = 2'h1,
        ACS_ST_ACQ = 2'h2,
        ACS_ST_CONV = 2'h3
    } acs_state_e;

    typedef struct packed {
        logic [7:0] precharge_time_count;
        logic [7:0] acquisition_time_count;
        logic [7:0] extra_hold_capacitance;
    } acs_timing_s;

    typedef struct packed {
        logic [2:0] computation_mode_select;
        logic [2:0] result_shift;
        logic [7:0] repeat_target;
    } acs_comp_s;
endpackage : acs_pkg

// >>> logic/acs_compute.sv
`timescale 1ns/10ps
module acs_compute
    import acs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic sample_in,
    input wire logic second_in,
    input wire logic double_in,
    input wire logic [ACS_RES_W-1:0] result_in,
    input wire logic [ACS_RES_W-1:0] previous_in,
    input wire acs_comp_s comp_in,
    output logic [ACS_ACC_W-1:0] acc_out,
    output logic [7:0] count_out,
    output logic overflow_out,
    output logic [ACS_ACC_W-1:0] filter_out,
    output logic test_out
);
    logic signed [ACS_ACC_W-1:0] term;
    logic signed [ACS_ACC_W-1:0] acc_shifted;
    logic signed [ACS_ACC_W:0] sum_next;
    logic [7:0] count_next;
    logic update;
    logic restart;
    acs_mode_e mode;

    assign mode = acs_mode_e'(comp_in.computation_mode_select);
    // Difference of two samples when double sampling
    assign term = double_in ? ACS_ACC_W'($signed({1'b0, result_in}) - $signed({1'b0, previous_in}))
                            : ACS_ACC_W'({1'b0, result_in});
    // Arithmetic shift floors, no rounding
    assign acc_shifted = $signed(acc_out) >>> comp_in.result_shift;
    assign update = sample_in && (!double_in || second_in);
    assign restart = (mode == ACS_MD_AVG) && (count_out >= comp_in.repeat_target);

    always_comb begin
        sum_next = {term[ACS_ACC_W-1], term} + {acc_out[ACS_ACC_W-1], acc_out};
        count_next = (count_out == ACS_CNT_MAX) ? count_out : count_out + 8'h01;
        if (restart) begin
            sum_next = {term[ACS_ACC_W-1], term};
            count_next = 8'h01;
        end
        if (mode == ACS_MD_LPF) begin
            sum_next = {term[ACS_ACC_W-1], term} + {acc_out[ACS_ACC_W-1], acc_out}
                     - {acc_shifted[ACS_ACC_W-1], acc_shifted};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            acc_out <= '0;
            count_out <= 8'h00;
            overflow_out <= 1'b0;
        end else if (update && mode != ACS_MD_BASIC && mode <= ACS_MD_LPF) begin
            acc_out <= sum_next[ACS_ACC_W-1:0];
            count_out <= count_next;
            if (sum_next[ACS_ACC_W] != sum_next[ACS_ACC_W-1]) begin
                overflow_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            filter_out <= '0;
        end else if (mode == ACS_MD_LPF) begin
            filter_out <= acc_out;
        end else begin
            filter_out <= acc_shifted;
        end
    end

    // Threshold test pulse one cycle after the update
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            test_out <= 1'b0;
        end else if (update) begin
            unique case (mode)
                ACS_MD_BASIC, ACS_MD_ACCUM: test_out <= 1'b1;
                ACS_MD_AVG, ACS_MD_BURST, ACS_MD_LPF: test_out <= (count_next >= comp_in.repeat_target);
                default: test_out <= 1'b0;
            endcase
        end else begin
            test_out <= 1'b0;
        end
    end

    property p_clear_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        clear_in |=> (acc_out == '0 && count_out == 8'h00 && !overflow_out);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear failed");
    property p_basic_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode == ACS_MD_BASIC && !clear_in) |=> $stable(acc_out);
    endproperty
    a_basic_hold: assert property (p_basic_hold) else $error("basic changed acc");
    property p_saturate;
        @(posedge clk_in) disable iff (!rst_n_in)
        (count_out == ACS_CNT_MAX && !clear_in && mode != ACS_MD_AVG) |=> count_out == ACS_CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");
    property p_avg_restart;
        @(posedge clk_in) disable iff (!rst_n_in)
        (update && restart && !clear_in) |=> count_out == 8'h01;
    endproperty
    a_avg_restart: assert property (p_avg_restart) else $error("average restart");
endmodule : acs_compute

// >>> logic/acs_sequencer.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [31:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [31:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic [ACS_RES_W-1:0] CONVERSION_RESULT_IN,
    input wire logic CONVERSION_END_IN,
    output logic PRECHARGE_ACTIVE_OUT,
    output logic PIN_OVERRIDE_OUT,
    output logic HOLD_CONNECT_OUT,
    output logic CONVERT_START_OUT,
    output logic [7:0] EXTRA_HOLD_CAPACITANCE_OUT,
    output logic GUARD_OUT_A_OUT,
    output logic GUARD_OUT_B_OUT,
    output logic CONVERSION_DONE_FLAG_OUT,
    output logic THRESHOLD_TEST_OUT
);
    acs_state_e state_reg;
    acs_timing_s timing_reg;
    acs_comp_s comp_reg;
    logic go_reg;
    logic dsen_reg;
    logic gpol_reg;
    logic ipen_reg;
    logic aclr_reg;
    logic second_reg;
    logic [8:0] timer_reg;
    logic done_reg;
    logic [ACS_RES_W-1:0] result_reg;
    logic [ACS_RES_W-1:0] previous_reg;
    logic guard_a_reg;
    logic guard_b_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic bvalid_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg;
    logic [1:0] rresp_reg;
    logic write_fire;
    logic go_write;
    logic sample_pulse;
    logic retrigger;
    logic [8:0] acq_len;
    logic acq_hw;
    logic [ACS_ACC_W-1:0] acc_value;
    logic [7:0] sample_counter;
    logic accumulator_overflow;
    logic [ACS_ACC_W-1:0] filter_output;
    logic test_pulse;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic wstrb0_reg;
    logic wstrb0;

    // AXI write: address and data may arrive in either order
    assign S_AXI_AWREADY_OUT = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY_OUT = !w_held_reg && !bvalid_reg;
    assign S_AXI_BVALID_OUT = bvalid_reg;
    assign S_AXI_BRESP_OUT = bresp_reg;
    assign S_AXI_ARREADY_OUT = !rvalid_reg;
    assign S_AXI_RVALID_OUT = rvalid_reg;
    assign S_AXI_RDATA_OUT = rdata_reg;
    assign S_AXI_RRESP_OUT = rresp_reg;
    assign waddr = aw_held_reg ? awaddr_reg : S_AXI_AWADDR_IN;
    assign wdata = w_held_reg ? wdata_reg : S_AXI_WDATA_IN;
    // Strobe kept with held data so a late address still sees it
    assign wstrb0 = w_held_reg ? wstrb0_reg : S_AXI_WSTRB_IN[0];
    assign write_fire = (aw_held_reg || (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT))
                     && (w_held_reg || (S_AXI_WVALID_IN && S_AXI_WREADY_OUT));
    assign go_write = write_fire && ((waddr & ACS_ADDR_MASK) == ACS_OFS_CTRL) && wstrb0
                   && wdata[ACS_CTRL_GO];

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ACS_RESP_OKAY;
        end else if (write_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            unique case (waddr & ACS_ADDR_MASK)
                ACS_OFS_CTRL, ACS_OFS_TIME, ACS_OFS_COMP: bresp_reg <= ACS_RESP_OKAY;
                default: bresp_reg <= ACS_RESP_DECERR;
            endcase
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_held_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA_IN;
                wstrb0_reg <= S_AXI_WSTRB_IN[0];
            end
            if (bvalid_reg && S_AXI_BREADY_IN) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            timing_reg <= '0;
            comp_reg <= '0;
            dsen_reg <= 1'b0;
            gpol_reg <= 1'b0;
            ipen_reg <= 1'b0;
            aclr_reg <= 1'b0;
        end else begin
            aclr_reg <= 1'b0;
            if (write_fire && wstrb0) begin
                unique case (waddr & ACS_ADDR_MASK)
                    ACS_OFS_CTRL: begin
                        dsen_reg <= wdata[ACS_CTRL_DSEN];
                        gpol_reg <= wdata[ACS_CTRL_GPOL];
                        ipen_reg <= wdata[ACS_CTRL_IPEN];
                        aclr_reg <= wdata[ACS_CTRL_ACLR];
                    end
                    ACS_OFS_TIME: timing_reg <= wdata[23:0];
                    ACS_OFS_COMP: comp_reg <= wdata[13:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= ACS_RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= ACS_RESP_OKAY;
            unique case (S_AXI_ARADDR_IN & ACS_ADDR_MASK)
                ACS_OFS_CTRL: rdata_reg <= {27'h0, 1'b0, ipen_reg, gpol_reg, dsen_reg, go_reg};
                ACS_OFS_TIME: rdata_reg <= {8'h00, timing_reg};
                ACS_OFS_COMP: rdata_reg <= {18'h0, comp_reg};
                ACS_OFS_STAT: rdata_reg <= {21'h0, second_reg, accumulator_overflow, sample_counter, done_reg};
                ACS_OFS_ACC: rdata_reg <= {filter_output, acc_value};
                ACS_OFS_RES: rdata_reg <= {6'h00, previous_reg, 6'h00, result_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= ACS_RESP_DECERR;
                end
            endcase
        end else if (rvalid_reg && S_AXI_RREADY_IN) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Zero count: 256 cycles with precharge, no hardware timing without
    assign acq_len = (timing_reg.acquisition_time_count == 8'h00) ? ACS_ACQ_MAX
                   : {1'b0, timing_reg.acquisition_time_count};
    assign acq_hw = (timing_reg.precharge_time_count != 8'h00)
                 || (timing_reg.acquisition_time_count != 8'h00);
    assign sample_pulse = (state_reg == ACS_ST_CONV) && CONVERSION_END_IN;
    // Burst mode restarts until the counter reaches the target
    assign retrigger = sample_pulse && !aclr_reg
                    && (comp_reg.computation_mode_select == ACS_MD_BURST)
                    && ((!dsen_reg) || second_reg)
                    && ({1'b0, sample_counter} + 9'h001 < {1'b0, comp_reg.repeat_target});
    assign CONVERT_START_OUT = (state_reg == ACS_ST_CONV);
    assign PRECHARGE_ACTIVE_OUT = (state_reg == ACS_ST_PRE);
    assign PIN_OVERRIDE_OUT = (state_reg == ACS_ST_PRE);
    assign HOLD_CONNECT_OUT = (state_reg != ACS_ST_PRE);
    assign EXTRA_HOLD_CAPACITANCE_OUT = (state_reg == ACS_ST_CONV) ? 8'h00
                                      : timing_reg.extra_hold_capacitance;
    assign GUARD_OUT_A_OUT = guard_a_reg;
    assign GUARD_OUT_B_OUT = guard_b_reg;
    assign CONVERSION_DONE_FLAG_OUT = done_reg;
    assign THRESHOLD_TEST_OUT = test_pulse;

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            state_reg <= ACS_ST_IDLE;
            timer_reg <= 9'h000;
            go_reg <= 1'b0;
            second_reg <= 1'b0;
            guard_a_reg <= 1'b0;
            guard_b_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ACS_ST_IDLE: begin
                    if (go_write || go_reg) begin
                        go_reg <= 1'b1;
                        if (timing_reg.precharge_time_count != 8'h00) begin
                            state_reg <= ACS_ST_PRE;
                            timer_reg <= {1'b0, timing_reg.precharge_time_count};
                            // Inverted precharge flips the second sample's guards
                            guard_a_reg <= gpol_reg ^ (second_reg && ipen_reg);
                            guard_b_reg <= gpol_reg ^ (second_reg && ipen_reg);
                        end else if (acq_hw) begin
                            state_reg <= ACS_ST_ACQ;
                            timer_reg <= acq_len;
                            guard_a_reg <= ~guard_a_reg;
                        end else begin
                            state_reg <= ACS_ST_CONV;
                        end
                    end
                end
                ACS_ST_PRE: begin
                    if (timer_reg == 9'h001) begin
                        state_reg <= ACS_ST_ACQ;
                        timer_reg <= acq_len;
                        guard_a_reg <= ~guard_a_reg;
                    end else begin
                        timer_reg <= timer_reg - 9'h001;
                    end
                end
                ACS_ST_ACQ: begin
                    if (timer_reg == 9'h001) begin
                        state_reg <= ACS_ST_CONV;
                    end else begin
                        timer_reg <= timer_reg - 9'h001;
                    end
                end
                ACS_ST_CONV: begin
                    if (CONVERSION_END_IN) begin
                        state_reg <= ACS_ST_IDLE;
                        // A go written as the sequence ends is kept
                        go_reg <= retrigger || go_write;
                        second_reg <= dsen_reg && !second_reg;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            result_reg <= '0;
            previous_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (sample_pulse) begin
                previous_reg <= result_reg;
                result_reg <= CONVERSION_RESULT_IN;
                done_reg <= 1'b1;
            end
        end
    end

    acs_compute u_compute (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .clear_in(aclr_reg || (go_write && state_reg == ACS_ST_IDLE && !go_reg
                  && comp_reg.computation_mode_select == ACS_MD_BURST)),
        .sample_in(sample_pulse),
        .second_in(second_reg),
        .double_in(dsen_reg),
        .result_in(CONVERSION_RESULT_IN),
        .previous_in(result_reg),
        .comp_in(comp_reg),
        .acc_out(acc_value),
        .count_out(sample_counter),
        .overflow_out(accumulator_overflow),
        .filter_out(filter_output),
        .test_out(test_pulse)
    );

    property p_acq_after_pre;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (state_reg == ACS_ST_PRE && timer_reg == 9'h001) |=> state_reg == ACS_ST_ACQ;
    endproperty
    a_acq_after_pre: assert property (p_acq_after_pre) else $error("acquisition did not follow precharge");
    property p_acq_max;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        ($rose(state_reg == ACS_ST_ACQ) && timing_reg.acquisition_time_count == 8'h00) |-> timer_reg == ACS_ACQ_MAX;
    endproperty
    a_acq_max: assert property (p_acq_max) else $error("zero acquisition not 256");
    property p_guard_a_flip;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (state_reg == ACS_ST_PRE && timer_reg == 9'h001) |=> (guard_a_reg != $past(guard_a_reg)
        && $stable(guard_b_reg));
    endproperty
    a_guard_a_flip: assert property (p_guard_a_flip) else $error("guard A not inverted");
    property p_cap_off;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        state_reg == ACS_ST_CONV |-> EXTRA_HOLD_CAPACITANCE_OUT == 8'h00;
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capacitance during conversion");
    property p_done;
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        sample_pulse |=> CONVERSION_DONE_FLAG_OUT;
    endproperty
    a_done: assert property (p_done) else $error("done flag missing");
    c_precharge: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) state_reg == ACS_ST_PRE);
    c_burst: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) retrigger);
    c_test: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) test_pulse);
endmodule : acs_sequencer

// >>> testbench/acs_conv_model.sv
`timescale 1ns/10ps
module acs_conv_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [9:0] value_in,
    output logic end_out,
    output logic [9:0] result_out
);
    logic [2:0] wait_reg = 3'h0;
    logic slow_reg = 1'b0;
    initial begin
        end_out = 1'b0;
        result_out = 10'h000;
    end
    // Answers promptly and slowly in turn; the result bus only holds a value with the end pulse
    always @(posedge clk_in) begin
        if (start_in && !end_out && wait_reg == (slow_reg ? 3'h4 : 3'h1)) begin
            end_out <= 1'b1;
            result_out <= value_in;
            slow_reg <= !slow_reg;
            wait_reg <= 3'h0;
        end else begin
            end_out <= 1'b0;
            result_out <= ~result_out;
            wait_reg <= (start_in && !end_out) ? wait_reg + 3'h1 : 3'h0;
        end
    end
endmodule : acs_conv_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, cs_d = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cend, pre, ovr, hold, cst, ga, gb, done, tst;
    logic [1:0] bresp, rresp, r;
    logic [9:0] cres, feed = 10'h030, s;
    logic [7:0] cap;
    logic [15:0] acc;
    logic [3:0] g_acq;
    logic [1:0] g_pre;
    int miscompares = 0, samples_checked = 0, pre_n = 0, gap = 0, acq_n = 0, tests = 0, t0, k;
    always #4 clk = ~clk;
    acs_sequencer dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .CONVERSION_RESULT_IN(cres), .CONVERSION_END_IN(cend), .PRECHARGE_ACTIVE_OUT(pre),
        .PIN_OVERRIDE_OUT(ovr), .HOLD_CONNECT_OUT(hold), .CONVERT_START_OUT(cst),
        .EXTRA_HOLD_CAPACITANCE_OUT(cap), .GUARD_OUT_A_OUT(ga), .GUARD_OUT_B_OUT(gb),
        .CONVERSION_DONE_FLAG_OUT(done), .THRESHOLD_TEST_OUT(tst));
    acs_conv_model conv (.clk_in(clk), .start_in(cst), .value_in(feed), .end_out(cend), .result_out(cres));
    function automatic logic [9:0] lfsr(input logic [9:0] v);
        return {v[8:0], v[9] ^ v[6]};
    endfunction : lfsr
    function automatic logic [15:0] lpf(input logic [15:0] a, input logic [9:0] v, input int sh);
        return 16'(v) + a - (a >> sh);
    endfunction : lpf
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t expected %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("Checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic hang;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask : hang
    task automatic axw(input logic [31:0] a, input logic [31:0] v);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 50) hang();
    endtask : axw
    task automatic axr(input logic [31:0] a);
        int i;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (i == 50) hang();
    endtask : axr
    task automatic run(input logic [31:0] ctrl);
        int i;
        s = lfsr(feed);
        feed <= s;
        pre_n = 0;
        axw(ACS_OFS_CTRL, ctrl | 32'h1);
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        if (i == 400) hang();
    endtask : run
    task automatic cfg(input logic [2:0] md, input logic [2:0] sh, input logic [7:0] tg);
        axw(ACS_OFS_COMP, {18'h0, md, sh, tg});
        axw(ACS_OFS_CTRL, 32'h14);
        axr(ACS_OFS_ACC);
        chk(32'h0, d);
        acc = 16'h0;
        t0 = tests;
    endtask : cfg
    // Stage monitor: precharge length, acquisition length and pin states at conversion start
    always @(posedge clk) begin
        cs_d <= cst;
        if (pre) pre_n <= pre_n + 1;
        if (pre) g_pre <= {ga, gb};
        if (pre) chk(32'h5, 32'(cap));
        if (pre) gap <= 0;
        else if (!cst) gap <= gap + 1;
        if (cst && !cs_d) begin
            acq_n <= gap;
            g_acq <= {ga, gb, ovr, hold};
        end
        if (tst === 1'b1) tests <= tests + 1;
        if (cend) chk(32'h0, 32'(cap));
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        axr(ACS_OFS_STAT);
        chk(32'h0, d);
        axr(32'h40);
        chk(32'(ACS_RESP_DECERR), 32'(r));
        axw(ACS_OFS_TIME, 32'h0003_0205);
        cfg(ACS_MD_ACCUM, 3'h1, 8'h03);
        for (k = 0; k < 4; k++) begin
            run(32'h4);
            acc = acc + 16'(s);
            chk(32'd3, pre_n);
            chk(32'd2, acq_n);
            chk(32'h3, 32'(g_pre));
            chk(32'h5, 32'(g_acq));
        end
        axr(ACS_OFS_ACC);
        chk({acc >> 1, acc}, d);
        axr(ACS_OFS_STAT);
        chk(32'd4, 32'(d[8:1]));
        chk(32'd4, tests - t0);
        $display("accumulate test end");
        cfg(ACS_MD_ACCUM, 3'h0, 8'h01);
        run(32'hE);
        acc = -16'(s);
        run(32'hE);
        acc = acc + 16'(s);
        chk(32'h0, 32'(g_pre));
        chk(32'h9, 32'(g_acq));
        axr(ACS_OFS_ACC);
        chk(32'(acc), 32'(d[15:0]));
        chk(32'd1, tests - t0);
        $display("double sample test end");
        cfg(ACS_MD_LPF, 3'h2, 8'h03);
        for (k = 0; k < 3; k++) begin
            run(32'h0);
            acc = lpf(acc, s, 2);
        end
        axr(ACS_OFS_ACC);
        chk(32'(acc), 32'(d[15:0]));
        chk(32'(acc), 32'(d[31:16]));
        chk(32'd1, tests - t0);
        $display("lowpass test end");
        cfg(ACS_MD_AVG, 3'h1, 8'h02);
        for (k = 0; k < 3; k++) run(32'h0);
        axr(ACS_OFS_ACC);
        chk({6'h0, s >> 1, 6'h0, s}, d);
        axr(ACS_OFS_STAT);
        chk(32'd1, 32'(d[8:1]));
        chk(32'd1, tests - t0);
        $display("average test end");
        cfg(ACS_MD_BURST, 3'h0, 8'h03);
        run(32'h0);
        for (k = 0; k < 20; k++) begin
            axr(ACS_OFS_CTRL);
            if (d[0] === 1'b0) break;
        end
        if (k == 20) hang();
        axr(ACS_OFS_ACC);
        acc = 16'(s) * 16'd3;
        chk(32'(acc), 32'(d[15:0]));
        chk(32'd1, tests - t0);
        $display("burst test end");
        axw(ACS_OFS_COMP, 32'h0);
        axw(ACS_OFS_TIME, 32'h0001_0005);
        t0 = tests;
        run(32'h0);
        chk(32'd256, acq_n);
        axw(ACS_OFS_TIME, 32'h0);
        run(32'h0);
        chk(32'd0, pre_n);
        axr(ACS_OFS_ACC);
        chk(32'(acc), 32'(d[15:0]));
        chk(32'd2, tests - t0);
        $display("basic test end");
        wrap_up();
    end
endmodule : tb_top
